// ---- x21_cfg_pkg.sv ----
// Constants and types shared by the dual X.21 slot configuration block
package x21_cfg_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL0   = 8'h00;
  localparam logic [7:0]  OFF_CTRL1   = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [13:0] CTRL_RESET  = 14'h3E10;
  // Control fields: mode {high,low}, framing {frame,signalling}, head, tail
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FRM_LSB  = 2;
  localparam int CTRL_HEAD_LSB = 4;
  localparam int CTRL_TAIL_LSB = 9;
  localparam int STAT_CH_W     = 16;

  // ---------------------------------------------------------------
  // Switch bank positions (bit i is position i+1, ON reads 1)
  // ---------------------------------------------------------------
  localparam int SW_MODE_HIGH = 0;
  localparam int SW_MODE_LOW  = 1;
  localparam int SW_FRAME     = 2;
  localparam int SW_SIG       = 3;
  localparam int SW_TAIL_LSB  = 0;
  localparam int SW_HEAD_LSB  = 5;

  // ---------------------------------------------------------------
  // Timeslots and timing
  // ---------------------------------------------------------------
  localparam logic [4:0] SLOT_FRAMING = 5'h00;
  localparam logic [4:0] SLOT_SIGNAL  = 5'h10;
  localparam int CLK_MHZ          = 100;
  localparam int TIMING_HALF_NS   = 244;
  localparam int TIMING_HALF_CYC  = TIMING_HALF_NS * CLK_MHZ / 1000;
  localparam int BLINK_HALF_MS    = 50;
  localparam int BLINK_HALF_CYC   = BLINK_HALF_MS * CLK_MHZ * 1000;

  typedef enum logic [2:0] {
    MODE_DTE        = 3'h1,
    MODE_DCE_LINE   = 3'h2,
    MODE_DCE_MASTER = 3'h4
  } work_mode_t;

  typedef enum logic [3:0] {
    FRM_UNFRAMED = 4'h1,
    FRM_FRAMED   = 4'h2,
    FRM_MULTI    = 4'h4,
    FRM_INVALID  = 4'h8
  } framing_t;

endpackage : x21_cfg_pkg

// ---- x21_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module x21_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.first  = async_in;
    next_st.second = st.first;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.second;

endmodule : x21_sync

// ---- x21_activity_led.sv ----
// Activity indicator: blinks while events keep arriving, dark otherwise
`timescale 1ns/1ps
module x21_activity_led #(
  parameter int BLINK_HALF = 5000000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic activity,
  output logic      led
);

  typedef struct packed {
    logic [23:0] hold;
    logic [23:0] phase;
    logic        lit;
  } led_state_t;

  led_state_t st;
  led_state_t next_st;

  always_comb begin
    next_st = st;
    if (activity) begin
      next_st.hold = 24'(2 * BLINK_HALF);
    end else if (st.hold != 24'h000000) begin
      next_st.hold = st.hold - 24'h000001;
    end
    if (st.hold == 24'h000000) begin
      next_st.phase = 24'h000000;
      next_st.lit   = 1'b0;
    end else if (st.phase == 24'(BLINK_HALF - 1)) begin
      next_st.phase = 24'h000000;
      next_st.lit   = !st.lit;
    end else begin
      next_st.phase = st.phase + 24'h000001;
      if (st.phase == 24'h000000 && !st.lit) begin
        next_st.lit = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign led = st.lit;

endmodule : x21_activity_led

// ---- x21_dual_port.sv ----
// Dual X.21 channel: configuration, E1 slot selection, line timing, APB slave
`timescale 1ns/1ps
// Overview of operation
// RULE1: Two independent channels, each moving its own stream between line and E1.
// RULE2: Each channel acts as terminal or circuit side; role picks driven signals.
// RULE3: Mode bits: both on software, high DTE, low DCE line, none DCE master.
// RULE4: Framing bits: both multiframe, frame only framed, none unframed, sig only invalid.
// RULE5: Both mode switches on: mode and bandwidth come from software registers.
// RULE6: Otherwise mode and bandwidth come from the local switches.
// RULE7: Under switch control status stays readable; control writes are ignored.
// RULE8: Each channel owns one mode bank and one slot limit bank.
// RULE9: Head slot is a five-bit binary field, MSB first; 00111 is slot 7.
// RULE10: Tail slot is a separate five-bit binary field; 11111 is slot 31.
// RULE11: Head and tail apply only in framed or multiframe operation.
// RULE12: Unframed carries all 32 slots with no selection.
// RULE13: Framed carries at most 31 slots; slot 0 is kept for framing.
// RULE14: Multiframe carries at most 30 slots; slots 0 and 16 withheld.
// RULE15: Signalling mode reserves slot 16 for alignment and signalling.
// RULE16: Cross-connect traffic needs line-timed DCE, chosen by the configuring party.
// RULE17: Line-timed mode takes its bit timing from the E1 cross-connect clock.
// RULE18: Transmit indicator blinks while data leaves the port, else off.
// RULE19: Receive indicator blinks while data arrives at the port, else off.
// RULE20: DCE drives receive data, indication, timing; DTE drives transmit data, control.
module x21_dual_port #(
  parameter int BLINK_HALF = x21_cfg_pkg::BLINK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  mode_switch_bank_a,
  input  wire logic [3:0]  mode_switch_bank_b,
  input  wire logic [9:0]  slot_limit_switch_bank_a,
  input  wire logic [9:0]  slot_limit_switch_bank_b,
  input  wire logic        e1_bit_strobe,
  input  wire logic [4:0]  e1_slot,
  input  wire logic [1:0]  e1_rx_bit,
  output logic      [1:0]  e1_tx_bit,
  output logic      [1:0]  e1_tx_valid,
  input  wire logic [1:0]  line_t_in,
  output logic      [1:0]  line_t_out,
  output logic      [1:0]  line_t_oe,
  input  wire logic [1:0]  line_c_in,
  output logic      [1:0]  line_c_out,
  output logic      [1:0]  line_c_oe,
  input  wire logic [1:0]  line_r_in,
  output logic      [1:0]  line_r_out,
  output logic      [1:0]  line_r_oe,
  input  wire logic [1:0]  line_i_in,
  output logic      [1:0]  line_i_out,
  output logic      [1:0]  line_i_oe,
  input  wire logic [1:0]  line_s_in,
  output logic      [1:0]  line_s_out,
  output logic      [1:0]  line_s_oe,
  output logic      [1:0]  tx_led,
  output logic      [1:0]  rx_led
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0][13:0] ctrl;
    logic [1:0]       s_out;
    logic [1:0]       s_prev;
    logic [1:0][4:0]  s_cnt;
    logic [5:0]       master_cnt;
    logic [1:0]       data_out;
    logic [1:0]       ctl_out;
    logic [1:0]       dce_oe;
    logic [1:0]       dte_oe;
    logic [1:0]       tx_bit;
    logic [1:0]       tx_valid;
    logic [1:0]       tx_evt;
    logic [1:0]       rx_evt;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  // ---------------------------------------------------------------
  // Synchronisers for switches and line pins
  // ---------------------------------------------------------------
  logic [27:0]     sw_sync;
  logic [9:0]      line_sync;
  logic [1:0][3:0] msw;
  logic [1:0][9:0] lsw;
  logic [1:0]      t_sync;
  logic [1:0]      c_sync;
  logic [1:0]      r_sync;
  logic [1:0]      i_sync;
  logic [1:0]      s_sync;

  // RULE8 separate banks
  x21_sync #(.WIDTH(28)) u_sw_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({slot_limit_switch_bank_b, slot_limit_switch_bank_a, mode_switch_bank_b, mode_switch_bank_a}),
    .sync_out (sw_sync)
  );

  x21_sync #(.WIDTH(10)) u_line_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({line_s_in, line_i_in, line_r_in, line_c_in, line_t_in}),
    .sync_out (line_sync)
  );

  assign msw    = sw_sync[7:0];
  assign lsw    = sw_sync[27:8];
  assign t_sync = line_sync[1:0];
  assign c_sync = line_sync[3:2];
  assign r_sync = line_sync[5:4];
  assign i_sync = line_sync[7:6];
  assign s_sync = line_sync[9:8];

  // ---------------------------------------------------------------
  // Effective configuration per channel
  // ---------------------------------------------------------------
  logic [1:0]             soft_ctl;
  x21_cfg_pkg::work_mode_t [1:0] mode;
  x21_cfg_pkg::framing_t [1:0] framing;
  logic [1:0][4:0]        head;
  logic [1:0][4:0]        tail;
  logic [1:0]             slot_act;
  logic [1:0]             is_dce;
  logic [1:0]             cfg_ok;
  logic [1:0][1:0]        mode_bits;
  logic [1:0][1:0]        frm_bits;

  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      // RULE5 software selects
      soft_ctl[ch] = msw[ch][x21_cfg_pkg::SW_MODE_HIGH] & msw[ch][x21_cfg_pkg::SW_MODE_LOW];
      // RULE6 switches select
      if (soft_ctl[ch]) begin
        mode_bits[ch] = st.ctrl[ch][x21_cfg_pkg::CTRL_MODE_LSB +: 2];
        frm_bits[ch]  = st.ctrl[ch][x21_cfg_pkg::CTRL_FRM_LSB +: 2];
        head[ch]      = st.ctrl[ch][x21_cfg_pkg::CTRL_HEAD_LSB +: 5];
        tail[ch]      = st.ctrl[ch][x21_cfg_pkg::CTRL_TAIL_LSB +: 5];
      end else begin
        mode_bits[ch] = {msw[ch][x21_cfg_pkg::SW_MODE_HIGH], msw[ch][x21_cfg_pkg::SW_MODE_LOW]};
        frm_bits[ch]  = {msw[ch][x21_cfg_pkg::SW_FRAME], msw[ch][x21_cfg_pkg::SW_SIG]};
        // RULE9 head field MSB first
        head[ch]      = lsw[ch][x21_cfg_pkg::SW_HEAD_LSB +: 5];
        // RULE10 tail field MSB first
        tail[ch]      = lsw[ch][x21_cfg_pkg::SW_TAIL_LSB +: 5];
      end
      // RULE3 mode decode
      case (mode_bits[ch])
        2'h2:    mode[ch] = x21_cfg_pkg::MODE_DTE;
        2'h1:    mode[ch] = x21_cfg_pkg::MODE_DCE_LINE;
        default: mode[ch] = x21_cfg_pkg::MODE_DCE_MASTER;
      endcase
      // RULE4 framing decode
      case (frm_bits[ch])
        2'h3:    framing[ch] = x21_cfg_pkg::FRM_MULTI;
        2'h2:    framing[ch] = x21_cfg_pkg::FRM_FRAMED;
        2'h0:    framing[ch] = x21_cfg_pkg::FRM_UNFRAMED;
        default: framing[ch] = x21_cfg_pkg::FRM_INVALID;
      endcase
      is_dce[ch] = (mode[ch] != x21_cfg_pkg::MODE_DTE);
      cfg_ok[ch] = (framing[ch] != x21_cfg_pkg::FRM_INVALID);
      // RULE11 limits ignored unframed
      // RULE12 all slots unframed
      // RULE13 slot 0 withheld framed
      // RULE14 slots 0 and 16 withheld
      // RULE15 signalling slot reserved
      case (framing[ch])
        x21_cfg_pkg::FRM_UNFRAMED: slot_act[ch] = 1'b1;
        x21_cfg_pkg::FRM_FRAMED:   slot_act[ch] = (e1_slot != x21_cfg_pkg::SLOT_FRAMING)
                                                  && (e1_slot >= head[ch]) && (e1_slot <= tail[ch]);
        x21_cfg_pkg::FRM_MULTI:    slot_act[ch] = (e1_slot != x21_cfg_pkg::SLOT_FRAMING)
                                                  && (e1_slot != x21_cfg_pkg::SLOT_SIGNAL)
                                                  && (e1_slot >= head[ch]) && (e1_slot <= tail[ch]);
        default:                   slot_act[ch] = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Line timing, data and APB
  // ---------------------------------------------------------------
  logic [1:0] tick;
  logic [1:0] s_lvl;
  logic       master_tick;
  logic       access;

  assign master_tick = (st.master_cnt == 6'h00);
  assign access      = psel & penable & !st.pready;

  always_comb begin
    next_st          = st;
    next_st.tx_valid = 2'h0;
    next_st.tx_evt   = 2'h0;
    next_st.rx_evt   = 2'h0;
    tick             = 2'h0;
    s_lvl            = 2'h0;
    if (st.master_cnt == 6'(2 * x21_cfg_pkg::TIMING_HALF_CYC - 1)) begin
      next_st.master_cnt = 6'h00;
    end else begin
      next_st.master_cnt = st.master_cnt + 6'h01;
    end
    // RULE1 per-channel engines
    for (int ch = 0; ch < 2; ch++) begin
      // RULE17 line timing from E1
      if (mode[ch] == x21_cfg_pkg::MODE_DCE_LINE) begin
        tick[ch] = e1_bit_strobe & slot_act[ch];
      end else if (mode[ch] == x21_cfg_pkg::MODE_DCE_MASTER) begin
        tick[ch] = master_tick & cfg_ok[ch];
      end
      // RULE2 role sets drivers
      // RULE20 DCE timing, DTE data
      next_st.dce_oe[ch]  = is_dce[ch];
      next_st.dte_oe[ch]  = !is_dce[ch];
      next_st.ctl_out[ch] = cfg_ok[ch];
      if (!is_dce[ch]) begin
        next_st.s_out[ch] = 1'b0;
        next_st.s_cnt[ch] = 5'h00;
      end else if (tick[ch]) begin
        next_st.s_out[ch] = 1'b1;
        next_st.s_cnt[ch] = 5'(x21_cfg_pkg::TIMING_HALF_CYC);
      end else if (st.s_cnt[ch] != 5'h00) begin
        next_st.s_cnt[ch] = st.s_cnt[ch] - 5'h01;
        if (st.s_cnt[ch] == 5'h01) begin
          next_st.s_out[ch] = 1'b0;
        end
      end
      s_lvl[ch]          = is_dce[ch] ? st.s_out[ch] : s_sync[ch];
      next_st.s_prev[ch] = s_lvl[ch];
      if (s_lvl[ch] && !st.s_prev[ch] && cfg_ok[ch]) begin
        next_st.data_out[ch] = e1_rx_bit[ch];
        // RULE18 transmit activity
        next_st.tx_evt[ch]   = st.ctl_out[ch];
      end
      if (!s_lvl[ch] && st.s_prev[ch] && cfg_ok[ch]) begin
        next_st.tx_bit[ch]   = is_dce[ch] ? t_sync[ch] : r_sync[ch];
        next_st.tx_valid[ch] = 1'b1;
        // RULE19 receive activity
        next_st.rx_evt[ch]   = is_dce[ch] ? c_sync[ch] : i_sync[ch];
      end
    end
    // One wait state: pready raised in second access cycle
    next_st.pready  = access;
    next_st.pslverr = 1'b0;
    if (access) begin
      next_st.prdata = 32'h00000000;
      if (paddr == x21_cfg_pkg::OFF_CTRL0 || paddr == x21_cfg_pkg::OFF_CTRL1) begin
        next_st.prdata = {18'h00000, st.ctrl[paddr[2]]};
        // RULE7 writes ignored under switches
        if (pwrite && soft_ctl[paddr[2]] && pwdata[1:0] != 2'h3) begin
          next_st.ctrl[paddr[2]] = pwdata[13:0];
        end
      end else if (paddr == x21_cfg_pkg::OFF_STATUS) begin
        // RULE7 status always readable
        for (int ch = 0; ch < 2; ch++) begin
          next_st.prdata[ch * x21_cfg_pkg::STAT_CH_W +: x21_cfg_pkg::STAT_CH_W] =
            {4'h0, rx_led[ch], tx_led[ch], 2'h0, soft_ctl[ch], framing[ch], mode[ch]};
        end
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= '0;
      st.ctrl <= {x21_cfg_pkg::CTRL_RESET, x21_cfg_pkg::CTRL_RESET};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Activity indicators
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_led
    x21_activity_led #(.BLINK_HALF(BLINK_HALF)) u_tx_led (
      .pclk     (pclk),
      .presetn  (presetn),
      .activity (st.tx_evt[ch]),
      .led      (tx_led[ch])
    );
    x21_activity_led #(.BLINK_HALF(BLINK_HALF)) u_rx_led (
      .pclk     (pclk),
      .presetn  (presetn),
      .activity (st.rx_evt[ch]),
      .led      (rx_led[ch])
    );
  end

  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign e1_tx_bit   = st.tx_bit;
  assign e1_tx_valid = st.tx_valid;
  assign line_t_out  = st.data_out;
  assign line_r_out  = st.data_out;
  assign line_c_out  = st.ctl_out;
  assign line_i_out  = st.ctl_out;
  assign line_s_out  = st.s_out;
  assign line_t_oe   = st.dte_oe;
  assign line_c_oe   = st.dte_oe;
  assign line_r_oe   = st.dce_oe;
  assign line_i_oe   = st.dce_oe;
  assign line_s_oe   = st.dce_oe;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable && !pready;
  endsequence

  a_apb_one_wait: assert property (s_access |=> pready) // RULE7
    else $error("APB answer not one cycle after access");
  a_switch_write_blocked: assert property ((s_access and (pwrite && paddr == x21_cfg_pkg::OFF_CTRL1 && !soft_ctl[1]))
      |=> $stable(st.ctrl[1])) // RULE7
    else $error("Control changed under switch control");
  a_dte_oe: assert property (mode[0] == x21_cfg_pkg::MODE_DTE |=> line_t_oe[0] && !line_s_oe[0]) // RULE20
    else $error("DTE role drives wrong lines");
  a_dce_oe: assert property (is_dce[1] |=> line_r_oe[1] && line_i_oe[1] && !line_c_oe[1]) // RULE2
    else $error("DCE role drives wrong lines");
  a_slot_zero: assert property (framing[1] != x21_cfg_pkg::FRM_UNFRAMED && e1_slot == 5'h00 |-> !slot_act[1]) // RULE13
    else $error("Framing slot selected");
  a_slot_sixteen: assert property (framing[1] == x21_cfg_pkg::FRM_MULTI && e1_slot == 5'h10 |-> !slot_act[1]) // RULE15
    else $error("Signalling slot selected");
  a_unframed_all: assert property (framing[1] == x21_cfg_pkg::FRM_UNFRAMED |-> slot_act[1]) // RULE12
    else $error("Unframed slot dropped");
  a_soft_select: assert property (soft_ctl[0] |-> mode_bits[0] == st.ctrl[0][1:0]) // RULE5
    else $error("Software mode not used");
  a_line_timing: assert property (mode[1] == x21_cfg_pkg::MODE_DCE_LINE && e1_bit_strobe && slot_act[1]
      |=> line_s_out[1] ##24 !line_s_out[1]) // RULE17
    else $error("Line timing pulse wrong");
  a_invalid_idle: assert property (framing[0] == x21_cfg_pkg::FRM_INVALID |=> !e1_tx_valid[0]) // RULE4
    else $error("Invalid framing moved data");

endmodule : x21_dual_port

// ---- x21_far_end.sv ----
// Far-end X.21 equipment model facing one channel
`timescale 1ns/1ps
module x21_far_end (
  input  wire logic dev_dte,
  input  wire logic dev_dce,
  input  wire logic data_bit,
  output logic      t_val,
  output logic      c_val,
  output logic      r_val,
  output logic      i_val,
  output logic      s_val
);
  // ---------------------------------------------------------------
  // Line drivers
  // ---------------------------------------------------------------
  // far side drives
  always_comb begin
    t_val = dev_dce ? data_bit : ~data_bit;
    c_val = dev_dce;
    r_val = dev_dte ? data_bit : ~data_bit;
    i_val = dev_dte;
  end
  // Timing runs only while the device is terminal
  initial s_val = 1'b0;
  always #62.5 s_val = dev_dte ? ~s_val : 1'b0;
endmodule : x21_far_end

// ---- x21_dual_port_tb.sv ----
// Self-checking bench for the dual X.21 configuration block
`timescale 1ns/1ps
module x21_dual_port_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        e1_bit_strobe = 1'b0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  mode_switch_bank_a = 4'h3, mode_switch_bank_b = 4'hE;
  logic [9:0]  slot_limit_switch_bank_a = 10'h0FF, slot_limit_switch_bank_b = 10'h0FF;
  logic [4:0]  e1_slot = 5'h00;
  logic [1:0]  e1_rx_bit = 2'h0, far_bit = 2'h3, e1_tx_bit, e1_tx_valid, tx_led, rx_led;
  logic [1:0]  line_t_in, line_t_out, line_t_oe, line_c_in, line_c_out, line_c_oe;
  logic [1:0]  line_r_in, line_r_out, line_r_oe, line_i_in, line_i_out, line_i_oe;
  logic [1:0]  line_s_in, line_s_out, line_s_oe, t_val, c_val, r_val, i_val, s_val;
  int          fails = 0, n_compared = 0, cyc = 0, txr, rxr;

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  assign line_t_in = (line_t_oe & line_t_out) | (~line_t_oe & t_val);
  assign line_c_in = (line_c_oe & line_c_out) | (~line_c_oe & c_val);
  assign line_r_in = (line_r_oe & line_r_out) | (~line_r_oe & r_val);
  assign line_i_in = (line_i_oe & line_i_out) | (~line_i_oe & i_val);
  assign line_s_in = (line_s_oe & line_s_out) | (~line_s_oe & s_val);

  x21_dual_port #(.BLINK_HALF(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_switch_bank_a(mode_switch_bank_a), .mode_switch_bank_b(mode_switch_bank_b),
    .slot_limit_switch_bank_a(slot_limit_switch_bank_a), .slot_limit_switch_bank_b(slot_limit_switch_bank_b),
    .e1_bit_strobe(e1_bit_strobe), .e1_slot(e1_slot), .e1_rx_bit(e1_rx_bit), .e1_tx_bit(e1_tx_bit),
    .e1_tx_valid(e1_tx_valid), .line_t_in(line_t_in), .line_t_out(line_t_out), .line_t_oe(line_t_oe),
    .line_c_in(line_c_in), .line_c_out(line_c_out), .line_c_oe(line_c_oe), .line_r_in(line_r_in),
    .line_r_out(line_r_out), .line_r_oe(line_r_oe), .line_i_in(line_i_in), .line_i_out(line_i_out),
    .line_i_oe(line_i_oe), .line_s_in(line_s_in), .line_s_out(line_s_out), .line_s_oe(line_s_oe),
    .tx_led(tx_led), .rx_led(rx_led));

  for (genvar k = 0; k < 2; k++) begin : g_far
    x21_far_end far_u (.dev_dte(line_t_oe[k]), .dev_dce(line_s_oe[k]), .data_bit(far_bit[k]),
      .t_val(t_val[k]), .c_val(c_val[k]), .r_val(r_val[k]), .i_val(i_val[k]), .s_val(s_val[k]));
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // One E1 bit on channel 1; checks timing pulse, outgoing and incoming data
  task strobe(input logic [4:0] slot, input logic exp_on);
    int n;
    logic seen, vseen;
    seen = 1'b0;
    vseen = 1'b0;
    @(posedge pclk);
    e1_slot <= slot; e1_rx_bit <= {slot[0], 1'b0}; e1_bit_strobe <= 1'b1;
    @(posedge pclk);
    e1_bit_strobe <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (n < 3 && line_s_out[1] === 1'b1) seen = 1'b1;
      if (n == 3 && exp_on) check(line_r_out[1], slot[0]);
      if (e1_tx_valid[1] === 1'b1) vseen = (e1_tx_bit[1] === far_bit[1]);
    end
    check(seen, exp_on);
    check(vseen, exp_on);
    repeat (15) @(posedge pclk);
  endtask : strobe

  task led_watch();
    logic tp, rp;
    txr = 0;
    rxr = 0;
    tp = tx_led[0];
    rp = rx_led[0];
    repeat (200) begin
      @(posedge pclk);
      if (tx_led[0] === 1'b1 && tp === 1'b0) txr++;
      if (rx_led[0] === 1'b1 && rp === 1'b0) rxr++;
      tp = tx_led[0];
      rp = rx_led[0];
    end
  endtask : led_watch

  task finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, x21_cfg_pkg::OFF_CTRL1, 32'h0000000E, rd, err);
    apb(1'b0, x21_cfg_pkg::OFF_CTRL1, 32'h0, rd, err);
    check(rd, {18'h0, x21_cfg_pkg::CTRL_RESET});
    apb(1'b1, x21_cfg_pkg::OFF_CTRL0, 32'h00003E12, rd, err);
    apb(1'b1, x21_cfg_pkg::OFF_CTRL0, 32'h00003E13, rd, err);
    apb(1'b0, x21_cfg_pkg::OFF_CTRL0, 32'h0, rd, err);
    check(rd, 32'h00003E12);
    apb(1'b0, 8'h0C, 32'h0, rd, err);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
    repeat (4) @(posedge pclk);
    apb(1'b0, x21_cfg_pkg::OFF_STATUS, 32'h0, rd, err);
    check(rd & 32'h03FF03FF, 32'h00220089);
    check({line_t_oe[0], line_r_oe[0], line_s_oe[1], line_t_oe[1]}, 4'hA);
    check({line_c_out[0], line_c_oe[0], line_i_out[1], line_i_oe[1]}, 4'hF);
    strobe(5'h07, 1'b1);
    strobe(5'h06, 1'b0);
    strobe(5'h10, 1'b0);
    strobe(5'h1F, 1'b1);
    strobe(5'h00, 1'b0);
    mode_switch_bank_b <= 4'h6;
    repeat (4) @(posedge pclk);
    strobe(5'h10, 1'b1);
    mode_switch_bank_b <= 4'hA;
    repeat (4) @(posedge pclk);
    strobe(5'h07, 1'b0);
    check(line_i_out[1], 1'b0);
    mode_switch_bank_b <= 4'h2;
    slot_limit_switch_bank_b <= 10'h3FF;
    repeat (4) @(posedge pclk);
    strobe(5'h00, 1'b1);
    strobe(5'h03, 1'b1);
    led_watch();
    check({txr >= 2, rxr >= 2}, 2'h3);
    check(e1_tx_bit[0], far_bit[0]);
    mode_switch_bank_a <= 4'hA;
    repeat (60) @(posedge pclk);
    led_watch();
    check(txr, 0);
    check(rxr, 0);
    check({tx_led[0], rx_led[0]}, 2'h0);
    finish_test();
  end
endmodule : x21_dual_port_tb
